/* File: design/front_panel_interface.sv */
// Front panel interface: address decode, knob counter, key column latch, row buffer, LEDs.
// Assumes the host drives address, direction and the I/O strobe from outside this clock.
`timescale 1ns/100ps
`include "fp_defs.svh"
module front_panel_interface
    import fp_pkg::*;
(
    // Clock and reset
    input  wire logic           clk_sys,
    input  wire logic           srst,
    // Host instrument bus
    input  wire fp_pkg::addr_t  bus_addr,
    input  wire logic           bus_read,
    input  wire logic           io_strobe_n,
    input  wire fp_pkg::byte_t  bus_data_in,
    output fp_pkg::byte_t       bus_data_out,
    output logic                bus_data_oe,
    // Decoded selects
    output logic                knob_count_clear_n,
    output logic                knob_count_read_n,
    output logic                key_column_write_n,
    output logic                key_row_read_n,
    output logic                lamp_write_n,
    // Rotary knob
    input  wire logic           rotary_knob_clk,
    input  wire logic           rotary_knob_up,
    // Keyboard
    output fp_pkg::byte_t       key_column,
    input  wire fp_pkg::byte_t  key_row,
    // Default key and lockout
    input  wire logic           default_key_n,
    input  wire logic           local_lockout,
    output logic                default_out_n,
    // System reset line and LEDs
    input  wire logic           sys_reset_n,
    output fp_pkg::byte_t       led
);
    import fp_pkg::*;

    logic  strobe_s;
    logic  rd_s;
    logic  knob_clk_s;
    logic  knob_up_s;
    logic  dkey_s;
    logic  lock_s;
    logic  sysrst_s;
    logic  knob_clk_d_r;
    logic  strobe_d_r;
    knob_t knob_r;
    byte_t led_r;
    byte_t row_s;
    bus_op_t op;
    logic  hit_clr;
    logic  hit_rd;
    logic  hit_col;
    logic  hit_rl;
    logic  stb_fall;

    // Address stays raw: host keeps it stable across the strobe, checked only with it
    pin_sync u_stb (.clk_sys(clk_sys), .srst(srst), .rst_val(1'b0),
                    .pin(~io_strobe_n), .level(strobe_s));
    pin_sync u_rd (.clk_sys(clk_sys), .srst(srst), .rst_val(1'b0),
                   .pin(bus_read), .level(rd_s));
    pin_sync u_kc (.clk_sys(clk_sys), .srst(srst), .rst_val(1'b0),
                   .pin(rotary_knob_clk), .level(knob_clk_s));
    pin_sync u_ku (.clk_sys(clk_sys), .srst(srst), .rst_val(1'b0),
                   .pin(rotary_knob_up), .level(knob_up_s));
    pin_sync u_dk (.clk_sys(clk_sys), .srst(srst), .rst_val(1'b0),
                   .pin(~default_key_n), .level(dkey_s));
    pin_sync u_lk (.clk_sys(clk_sys), .srst(srst), .rst_val(1'b0),
                   .pin(local_lockout), .level(lock_s));
    pin_sync u_sr (.clk_sys(clk_sys), .srst(srst), .rst_val(1'b0),
                   .pin(~sys_reset_n), .level(sysrst_s));

    // [R7] row sense pins, idle high
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_row
            pin_sync u_row (.clk_sys(clk_sys), .srst(srst), .rst_val(1'b1),
                            .pin(key_row[gi]), .level(row_s[gi]));
        end
    endgenerate

    always_comb
    begin
        hit_clr  = (bus_addr == `FP_ADDR_KNOB_CLR);
        hit_rd   = (bus_addr == `FP_ADDR_KNOB_RD);
        hit_col  = (bus_addr == `FP_ADDR_COL);
        hit_rl   = (bus_addr == `FP_ADDR_ROW_LED);
        stb_fall = strobe_s & ~strobe_d_r;
        if (!strobe_s)
            op = BUS_IDLE;
        else if (rd_s)
            op = BUS_READ;
        else
            op = BUS_WRITE;
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            strobe_d_r   <= 1'b0;
            knob_clk_d_r <= 1'b0;
        end
        else
        begin
            strobe_d_r   <= strobe_s;
            knob_clk_d_r <= knob_clk_s;
        end
    end

    // [R15] strobe-qualified selects
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            knob_count_clear_n <= 1'b1;
            knob_count_read_n  <= 1'b1;
            key_column_write_n <= 1'b1;
            key_row_read_n     <= 1'b1;
            lamp_write_n       <= 1'b1;
        end
        else
        begin
            knob_count_clear_n <= ~(op != BUS_IDLE && hit_clr);
            knob_count_read_n  <= ~(op == BUS_READ && hit_rd);
            key_column_write_n <= ~(op == BUS_WRITE && hit_col);
            key_row_read_n     <= ~(op == BUS_READ && hit_rl);
            lamp_write_n       <= ~(op == BUS_WRITE && hit_rl);
        end
    end

    // [R3] [R14] knob count with natural wrap; [R1] clear wins over a step
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            knob_r <= `FP_KNOB_RST;
        else if (op != BUS_IDLE && hit_clr)
            knob_r <= `FP_KNOB_RST;
        else if (knob_clk_s && !knob_clk_d_r)
            knob_r <= knob_up_s ? knob_r + 4'h1 : knob_r - 4'h1;
    end

    // [R2] [R13] [R11] read data on the low byte lane only
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            bus_data_out <= 8'h00;
            bus_data_oe  <= 1'b0;
        end
        else
        begin
            bus_data_oe <= (op == BUS_READ) && (hit_rd || hit_rl);
            if (op == BUS_READ && hit_rd)
                bus_data_out <= {4'h0, knob_r};
            else if (op == BUS_READ && hit_rl)
                bus_data_out <= row_s;
            else
                bus_data_out <= 8'h00;
        end
    end

    // [R6] [R12] column latch loads once per strobe
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            key_column <= `FP_COL_RST;
        else if (stb_fall && !rd_s && hit_col)
            key_column <= bus_data_in;
    end

    // [R5] [R13] LED register, one bit per lamp
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            led_r <= `FP_LED_RST;
        else if (stb_fall && !rd_s && hit_rl)
            led_r <= bus_data_in;
    end

    // [R8] system reset forces every lamp on
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            led <= `FP_LED_RST;
        else
            led <= sysrst_s ? `FP_ALL_ON : led_r;
    end

    // [R4] default key blocked under local lockout
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            default_out_n <= 1'b1;
        else
            default_out_n <= ~(dkey_s && !lock_s);
    end

    // [R15] select only with strobe and address
    sel_strobe_a: assert property (@(posedge clk_sys) disable iff (srst) // [R15]
        !lamp_write_n |-> $past(strobe_s) && !$past(rd_s) && $past(bus_addr) == `FP_ADDR_ROW_LED)
        else $error("lamp select without strobe or address");
    // [R1] clear access zeroes count
    knob_clear_a: assert property (@(posedge clk_sys) disable iff (srst) // [R1]
        !knob_count_clear_n |-> knob_r == 4'h0)
        else $error("knob count not zero after clear");
    // [R3] count up on clockwise step
    knob_up_a: assert property (@(posedge clk_sys) disable iff (srst) // [R3] [R14]
        (knob_clk_s && !knob_clk_d_r && knob_up_s && !(strobe_s && hit_clr))
        |=> knob_r == $past(knob_r) + 4'h1)
        else $error("knob count did not step up");
    // [R3] count down on counterclockwise step
    knob_down_a: assert property (@(posedge clk_sys) disable iff (srst) // [R3] [R14]
        (knob_clk_s && !knob_clk_d_r && !knob_up_s && !(strobe_s && hit_clr))
        |=> knob_r == $past(knob_r) - 4'h1)
        else $error("knob count did not step down");
    // [R2] read returns count
    knob_read_a: assert property (@(posedge clk_sys) disable iff (srst) // [R2]
        (op == BUS_READ && hit_rd) |=> bus_data_oe && bus_data_out == {4'h0, $past(knob_r)})
        else $error("knob read data wrong");
    // [R8] reset line lights lamps
    lamp_reset_a: assert property (@(posedge clk_sys) disable iff (srst) // [R8]
        sysrst_s |=> led == 8'hff)
        else $error("lamps not all on under reset line");
    // [R4] lockout suppresses default key
    key_lockout_a: assert property (@(posedge clk_sys) disable iff (srst) // [R4]
        lock_s |=> default_out_n)
        else $error("default key passed under lockout");
    // [R12] column write loads latch
    col_load_a: assert property (@(posedge clk_sys) disable iff (srst) // [R6] [R12]
        (stb_fall && !rd_s && hit_col) |=> key_column == $past(bus_data_in))
        else $error("column latch not loaded");
    // [R13] row read returns row buffer
    row_read_a: assert property (@(posedge clk_sys) disable iff (srst) // [R13]
        (op == BUS_READ && hit_rl) |=> bus_data_out == $past(row_s))
        else $error("row read data wrong");
endmodule

/* File: design/fp_defs.svh */
// Constants for the front panel interface: decoded addresses, widths, reset values.
// Assumes a byte-wide instrument bus with a 21-bit address and a 20 MHz system clock.
// Operation
// [R1] Any host access at the knob clear address sets the four-bit knob counter to zero.
// [R2] A host read at the knob read address returns the knob counter on the data bus.
// [R3] The knob counter counts up on a clockwise step and down on a counterclockwise step.
// [R4] The default key is suppressed while the instrument is in remote-bus local lockout.
// [R5] Each bit of the LED register drives one front panel LED independently.
// [R6] The column strobe latch holds the byte the host wrote and drives the column lines.
// [R7] A pressed key makes its row sense line follow its column line; strobes last about 7 ms.
// [R8] While the system reset line is held asserted, all LED outputs are driven on.
// [R9] On a detector supply short the host flashes the LEDs at 1.5 Hz.
// [R10] In the cycle exercise the host enables each decoded select and writes the column latch.
// [R11] All data uses only the least significant byte lane, bits 0 to 7.
// [R12] A host write at the column strobe address loads the column strobe latch.
// [R13] At the shared address a read returns the row buffer and a write loads the LED register.
// [R14] The knob counter wraps 1111 to 0000 going up and 0000 to 1111 going down.
// [R15] Each decoded select is active only while the I/O strobe is active and its address matches.
`ifndef FP_DEFS_SVH
`define FP_DEFS_SVH

`define FP_ADDR_W        21
`define FP_ADDR_KNOB_CLR 21'h1ff9b6
`define FP_ADDR_KNOB_RD  21'h1ff9b8
`define FP_ADDR_COL      21'h1ff9ba
`define FP_ADDR_ROW_LED  21'h1ff9be
`define FP_KNOB_W        4
`define FP_KNOB_RST      4'h0
`define FP_COL_RST       8'hff
`define FP_LED_RST       8'h00
`define FP_ALL_ON        8'hff
`define FP_CLK_NS        50
`define FP_STROBE_MS     7

`endif

/* File: design/fp_pkg.sv */
// Types shared by the front panel interface.
// Assumes fp_defs.svh is on the include path.
`include "fp_defs.svh"
package fp_pkg;
    typedef logic [7:0]                byte_t;
    typedef logic [`FP_ADDR_W-1:0]     addr_t;
    typedef logic [`FP_KNOB_W-1:0]     knob_t;
    typedef enum logic [1:0]
    {
        BUS_IDLE  = 2'b00,
        BUS_READ  = 2'b01,
        BUS_WRITE = 2'b10
    } bus_op_t;
endpackage

/* File: design/pin_sync.sv */
// Three-stage pin synchroniser with agreement filter.
// Assumes an asynchronous pin input and one system clock.
`timescale 1ns/100ps
module pin_sync
(
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic srst,
    input  wire logic rst_val,
    // Pin and filtered level
    input  wire logic pin,
    output logic      level
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    // Reset value is a port so each pin idles at its own inactive level
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            s1_r <= rst_val;
            s2_r <= rst_val;
            s3_r <= rst_val;
        end
        else
        begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // A change counts only when stages two and three agree
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            level <= rst_val;
        else if (s2_r == s3_r)
            level <= s2_r;
    end
endmodule

/* File: verif/host_cpu_model.sv */
// Host CPU model: strobed byte accesses on the instrument bus.
// Assumes the bench clock; returns read data and the decode seen.
`timescale 1ns/100ps
module host_cpu_model
    import fp_pkg::*;
(
    // Clock
    input  wire logic          clk_sys,
    // Host instrument bus
    output fp_pkg::addr_t      bus_addr,
    output logic               bus_read,
    output logic               io_strobe_n,
    output fp_pkg::byte_t      bus_data_in,
    input  wire fp_pkg::byte_t bus_data_out,
    input  wire logic [5:0]    seen
);
    initial
    begin
        bus_addr    = '0;
        bus_read    = 1'b0;
        io_strobe_n = 1'b1;
        bus_data_in = 8'h00;
    end

    // byte lane only
    // Strobe low 8 cycles, high 8; address held until the select drops
    task automatic access(input addr_t a, input logic rd, input byte_t wd,
                          output byte_t q, output logic [5:0] s);
        @(posedge clk_sys);
        #1;
        bus_addr    = a;
        bus_read    = rd;
        bus_data_in = rd ? ~wd : wd;
        io_strobe_n = 1'b0;
        repeat (8) @(posedge clk_sys);
        #1;
        q           = bus_data_out;
        s           = seen;
        io_strobe_n = 1'b1;
        repeat (8) @(posedge clk_sys);
        #1;
        bus_addr    = ~a;
        bus_data_in = ~bus_data_in;
    endtask
endmodule

/* File: verif/front_panel_interface_bench.sv */
// Self-checking bench for the front panel interface.
// Assumes fp_pkg is compiled and fp_defs.svh is on the include path.
`timescale 1ns/100ps
`include "fp_defs.svh"
module front_panel_interface_bench;
    import fp_pkg::*;
    logic  clk_sys, srst, rd, stb_n, oe, kclk, kup, dkey_n, lock, dout_n, sr_n;
    logic  clr_n, krd_n, colw_n, rowr_n, lamp_n;
    addr_t addr;
    byte_t din, dout, col, row, led, q, rnd;
    knob_t kexp;
    logic [2:0] kr, kc;
    int    err_count, tests_run;

    // Pressed key: its row follows its column
    assign row = ~(8'h01 << kr) | {8{col[kc]}};

    host_cpu_model host (.clk_sys(clk_sys), .bus_addr(addr), .bus_read(rd),
        .io_strobe_n(stb_n), .bus_data_in(din), .bus_data_out(dout),
        .seen({oe, clr_n, krd_n, colw_n, rowr_n, lamp_n}));

    front_panel_interface dut (.clk_sys(clk_sys), .srst(srst), .bus_addr(addr),
        .bus_read(rd), .io_strobe_n(stb_n), .bus_data_in(din),
        .bus_data_out(dout), .bus_data_oe(oe), .knob_count_clear_n(clr_n),
        .knob_count_read_n(krd_n), .key_column_write_n(colw_n),
        .key_row_read_n(rowr_n), .lamp_write_n(lamp_n), .rotary_knob_clk(kclk),
        .rotary_knob_up(kup), .key_column(col), .key_row(row),
        .default_key_n(dkey_n), .local_lockout(lock), .default_out_n(dout_n),
        .sys_reset_n(sr_n), .led(led));

    function automatic byte_t lfsr(input byte_t v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction

    // Expected {oe, five selects} during an access
    function automatic logic [5:0] exp_sel(input addr_t a, input logic r);
        case (a)
            `FP_ADDR_KNOB_CLR: return 6'h0f;
            `FP_ADDR_KNOB_RD:  return r ? 6'h37 : 6'h1f;
            `FP_ADDR_COL:      return r ? 6'h1f : 6'h1b;
            `FP_ADDR_ROW_LED:  return r ? 6'h3d : 6'h1e;
            default:           return 6'h1f;
        endcase
    endfunction

    task automatic chk(input byte_t got, input byte_t exp);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic acc(input addr_t a, input logic r, input byte_t wd);
        logic [5:0] s;
        host.access(a, r, wd, q, s);
        chk({2'h0, s}, {2'h0, exp_sel(a, r)});
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // Direction settles before the rising knob edge; steps 13 cycles apart
    task automatic step(input logic up);
        kup = up;
        tick(3);
        kclk = 1'b1;
        tick(5);
        kclk = 1'b0;
        tick(5);
        kexp = up ? kexp + 4'h1 : kexp - 4'h1;
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    initial
    begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        give_verdict();
    end

    initial
    begin
        srst = 1'b1;
        kclk = 1'b0;
        kup = 1'b0;
        dkey_n = 1'b1;
        lock = 1'b0;
        sr_n = 1'b1;
        kr = 3'h0;
        kc = 3'h0;
        rnd = 8'h49;
        tick(3);
        srst = 1'b0;
        chk(col, `FP_COL_RST);
        chk(led, `FP_LED_RST);
        // Host exercise: both knob addresses, a refused write, an unmapped read
        acc(`FP_ADDR_KNOB_CLR, 1'b0, 8'h00);
        acc(`FP_ADDR_KNOB_RD, 1'b0, 8'ha5);
        acc(21'h1ff9bc, 1'b1, 8'h00);
        kexp = 4'h0;
        for (int i = 0; i < 18; i++) step(1'b1);
        acc(`FP_ADDR_KNOB_RD, 1'b1, 8'h00);
        chk(q, 8'h02);
        acc(`FP_ADDR_KNOB_CLR, 1'b1, 8'h00);
        acc(`FP_ADDR_KNOB_RD, 1'b1, 8'h00);
        chk(q, 8'h00);
        kexp = 4'h0;
        step(1'b0);
        acc(`FP_ADDR_KNOB_RD, 1'b1, 8'h00);
        chk(q, 8'h0f);
        for (int i = 0; i < 12; i++)
        begin
            rnd = lfsr(rnd);
            step(rnd[0]);
        end
        acc(`FP_ADDR_KNOB_RD, 1'b1, 8'h00);
        chk(q, {4'h0, kexp});
        // Walking-one column pattern with one key held
        rnd = lfsr(rnd);
        kr = rnd[2:0];
        kc = rnd[5:3];
        for (int c = 0; c < 8; c++)
        begin
            acc(`FP_ADDR_COL, 1'b0, byte_t'(8'h01 << c));
            chk(col, byte_t'(8'h01 << c));
            acc(`FP_ADDR_ROW_LED, 1'b1, 8'h00);
            chk(q, (c == kc) ? 8'hff : ~(8'h01 << kr));
        end
        // Random patterns, then all-off and all-on as a fault flash does
        for (int i = 0; i < 8; i++)
        begin
            rnd = lfsr(rnd);
            if (i > 5)
                rnd = {8{i[0]}};
            acc(`FP_ADDR_ROW_LED, 1'b0, rnd);
            chk(led, rnd);
        end
        sr_n = 1'b0;
        tick(8);
        chk(led, `FP_ALL_ON);
        sr_n = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            dkey_n = i[0];
            lock = i[1];
            tick(8);
            chk({7'h00, dout_n}, {7'h00, i[0] | i[1]});
        end
        give_verdict();
    end
endmodule
